// ==== plt_launch_ctrl.sv ====
// playback launch control, sequencer walk and segment time trim registers
//
// Summary of operation
// - launch bit write starts mode-selected process
// - launch plays sequencer slots as software trigger
// - launch reads one until sequence completes, except in level trigger mode where it tracks the pin
// - host clearing launch abandons sequence at once
// - external trigger modes drive the launch bit
// - calibration or diagnostic mode starts that routine
// - full-scale samples form overdrive, get overdrive trim
// - overdrive trim signed, 5 ms per count
// - overdrive trim ignored in closed loop
// - other positive samples get positive sustain trim
// - positive sustain trim signed, 5 ms per count
// - other negative samples get negative sustain trim
// - negative sustain trim signed, 5 ms per count
// - walk slots in order, stop at zero
// - wait slot idles 10 ms per count
`timescale 1ns/1ps
module plt_launch_ctrl import plt_pkg::*; #(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input  logic         ref_clk,
  input  logic         nrst,
  // decoded register access
  input  plt_reg_req_s reg_req,
  output logic [7:0]   reg_rdata_r,
  // configuration from neighbouring registers
  input  logic [2:0]   mode,
  input  plt_slots_t   slots,
  input  logic         closed_loop,
  // external trigger pin
  input  logic         ext_trig,
  // waveform library
  output logic         wave_req_r,
  output logic [6:0]   wave_id_r,
  input  plt_seg_s     seg_in,
  input  logic         seg_valid,
  output logic         seg_ready_r,
  // output stage
  output logic         drive_en_r,
  output logic [7:0]   drive_amp_r,
  // calibration and diagnostics
  output logic         cal_start_r,
  output logic         diag_start_r,
  input  logic         routine_done
);
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_FETCH   = 3'b001,
    ST_SEG     = 3'b010,
    ST_HOLD    = 3'b011,
    ST_WAIT    = 3'b100,
    ST_ROUTINE = 3'b101
  } plt_state_e;

  plt_state_e st_r;
  logic       launch_r;
  logic [7:0] od_adj_r;
  logic [7:0] sp_adj_r;
  logic [7:0] sn_adj_r;
  logic [2:0] idx_r;
  logic [8:0] cnt_r;
  logic       last_r;
  logic       ext_q_r;
  logic       tick;
  logic       restart;
  logic [8:0] adj_ticks;
  logic [7:0] slot_cur;
  logic       host_wr_launch;
  logic       accept;
  logic       step;
  logic       finish;
  logic       cancel;
  logic       routine_mode;
  logic [9:0] od_sum_exp;

  assign slot_cur       = slots[idx_r];
  assign host_wr_launch = reg_req.wr && (reg_req.addr == ADDR_LAUNCH);
  assign accept         = (st_r == ST_SEG) && seg_valid && seg_ready_r;
  assign routine_mode   = (mode == MODE_CAL) || (mode == MODE_DIAG);
  assign cancel         = (st_r != ST_IDLE) && !launch_r;
  assign step           = ((st_r == ST_HOLD) && (cnt_r == 9'h000) && last_r)
                       || ((st_r == ST_WAIT) && (cnt_r == 9'h000));
  assign finish         = ((st_r == ST_FETCH) && (slot_cur == 8'h00))
                       || (step && (idx_r == 3'(NUM_SLOTS - 1)))
                       || ((st_r == ST_ROUTINE) && routine_done);
  assign restart        = accept || ((st_r == ST_FETCH) && slot_cur[WAIT_FLAG_BIT]);

  plt_tick_div #(.CYCLES(TICK_CYCLES_P)) u_tick (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .restart (restart),
    .tick    (tick)
  );

  plt_seg_adjust u_adj (
    .seg         (seg_in),
    .od_adj      (od_adj_r),
    .sp_adj      (sp_adj_r),
    .sn_adj      (sn_adj_r),
    .closed_loop (closed_loop),
    .adj_ticks   (adj_ticks)
  );

  // trim registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      od_adj_r <= RST_ADJ;
      sp_adj_r <= RST_ADJ;
      sn_adj_r <= RST_ADJ;
    end else if (reg_req.wr) begin
      if (reg_req.addr == ADDR_OD_ADJ) od_adj_r <= reg_req.wdata;
      if (reg_req.addr == ADDR_SP_ADJ) sp_adj_r <= reg_req.wdata;
      if (reg_req.addr == ADDR_SN_ADJ) sn_adj_r <= reg_req.wdata;
    end
  end

  // launch bit: host write wins, then trigger pin, then completion
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      launch_r <= RST_LAUNCH[LAUNCH_BIT];
      ext_q_r  <= 1'b0;
    end else begin
      ext_q_r <= ext_trig;
      if (host_wr_launch) begin
        launch_r <= reg_req.wdata[LAUNCH_BIT];
      end else if (mode == MODE_EXT_EDGE && ext_trig && !ext_q_r) begin
        launch_r <= 1'b1;
      end else if (mode == MODE_EXT_LEVEL) begin
        launch_r <= ext_trig;
      end else if (finish) begin
        launch_r <= 1'b0;
      end
    end
  end

  // read data
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_LAUNCH: reg_rdata_r <= {7'h00, launch_r};
        ADDR_OD_ADJ: reg_rdata_r <= od_adj_r;
        ADDR_SP_ADJ: reg_rdata_r <= sp_adj_r;
        ADDR_SN_ADJ: reg_rdata_r <= sn_adj_r;
        default:     reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // sequencer walk
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r         <= ST_IDLE;
      idx_r        <= 3'h0;
      cnt_r        <= 9'h000;
      last_r       <= 1'b0;
      wave_req_r   <= 1'b0;
      wave_id_r    <= 7'h00;
      seg_ready_r  <= 1'b0;
      drive_en_r   <= 1'b0;
      drive_amp_r  <= 8'h00;
      cal_start_r  <= 1'b0;
      diag_start_r <= 1'b0;
    end else begin
      wave_req_r   <= 1'b0;
      cal_start_r  <= 1'b0;
      diag_start_r <= 1'b0;
      if (cancel || finish) begin
        st_r        <= ST_IDLE;
        seg_ready_r <= 1'b0;
        drive_en_r  <= 1'b0;
        drive_amp_r <= 8'h00;
      end else begin
        unique case (st_r)
          ST_IDLE: begin
            if (launch_r && routine_mode) begin
              st_r         <= ST_ROUTINE;
              cal_start_r  <= (mode == MODE_CAL);
              diag_start_r <= (mode == MODE_DIAG);
            end else if (launch_r) begin
              st_r  <= ST_FETCH;
              idx_r <= 3'h0;
            end
          end
          ST_FETCH: begin
            if (slot_cur[WAIT_FLAG_BIT]) begin
              cnt_r <= 9'(slot_cur[6:0] * WAIT_TICKS);
              st_r  <= ST_WAIT;
            end else begin
              wave_req_r  <= 1'b1;
              wave_id_r   <= slot_cur[6:0];
              seg_ready_r <= 1'b1;
              st_r        <= ST_SEG;
            end
          end
          ST_SEG: begin
            if (accept) begin
              seg_ready_r <= 1'b0;
              cnt_r       <= adj_ticks;
              last_r      <= seg_in.last;
              drive_amp_r <= seg_in.amp;
              drive_en_r  <= (adj_ticks != 9'h000);
              st_r        <= ST_HOLD;
            end
          end
          ST_HOLD, ST_WAIT: begin
            if (cnt_r == 9'h000) begin
              drive_en_r <= 1'b0;
              if (step) begin
                idx_r <= idx_r + 3'h1;
                st_r  <= ST_FETCH;
              end else begin
                seg_ready_r <= 1'b1;
                st_r        <= ST_SEG;
              end
            end else if (tick) begin
              cnt_r <= cnt_r - 9'h001;
              if (cnt_r == 9'h001) drive_en_r <= 1'b0;
            end
          end
          ST_ROUTINE: begin
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // checks
  // overdrive length from nominal plus sign-extended trim, bit 9 marks underflow
  assign od_sum_exp = {2'b00, seg_in.dur} + {{2{od_adj_r[7]}}, od_adj_r};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_fetch_wave;
    (st_r == ST_FETCH) && launch_r && (slot_cur != 8'h00) && !slot_cur[WAIT_FLAG_BIT];
  endsequence
  sequence s_wave_issued;
    wave_req_r && seg_ready_r && (st_r == ST_SEG);
  endsequence

  a_launch_fetch: assert property ((st_r == ST_IDLE) && launch_r && !routine_mode
    |=> (st_r == ST_FETCH) && (idx_r == 3'h0)) else $error("launch did not start walk");
  a_wave_request: assert property (s_fetch_wave |=> s_wave_issued)
    else $error("slot not played");
  a_done_clear: assert property (finish && !host_wr_launch && mode == MODE_INT_TRIG
    |=> !launch_r && (st_r == ST_IDLE)) else $error("launch not cleared at end");
  a_cancel_stop: assert property (cancel |=> (st_r == ST_IDLE) && !drive_en_r)
    else $error("cancel did not stop playback");
  a_ext_edge: assert property (mode == MODE_EXT_EDGE && ext_trig && !ext_q_r
    && !host_wr_launch |=> launch_r) else $error("edge trigger missed");
  a_routine_go: assert property ((st_r == ST_IDLE) && launch_r && mode == MODE_CAL
    |=> cal_start_r && (st_r == ST_ROUTINE) && !wave_req_r)
    else $error("calibration not started");
  a_od_trim: assert property (accept && seg_in.amp == AMP_MAX && !closed_loop
    && !cancel |=> cnt_r == ($past(od_sum_exp[9]) ? 9'h000 : $past(od_sum_exp[8:0])))
    else $error("overdrive trim wrong");
  a_closed_skip: assert property (accept && seg_in.amp == AMP_MAX && closed_loop
    && !cancel |=> cnt_r == {1'b0, $past(seg_in.dur)}) else $error("trim used in closed loop");
  a_zero_stop: assert property ((st_r == ST_FETCH) && (slot_cur == 8'h00)
    |=> (st_r == ST_IDLE) && !wave_req_r) else $error("walk passed zero slot");
  a_wait_load: assert property ((st_r == ST_FETCH) && slot_cur[WAIT_FLAG_BIT] && !cancel
    |=> (st_r == ST_WAIT) && cnt_r == 9'($past(slot_cur[6:0]) * WAIT_TICKS))
    else $error("wait length wrong");
  a_clamp_zero: assert property (accept && adj_ticks == 9'h000 && !cancel
    |=> !drive_en_r ##1 st_r != ST_HOLD) else $error("zero length segment driven");
endmodule : plt_launch_ctrl

// ==== plt_pkg.sv ====
// shared constants and types for the playback launch and time trim block
package plt_pkg;
  // register map
  localparam logic [7:0] ADDR_LAUNCH = 8'h0C;
  localparam logic [7:0] ADDR_OD_ADJ = 8'h0D;
  localparam logic [7:0] ADDR_SP_ADJ = 8'h0E;
  localparam logic [7:0] ADDR_SN_ADJ = 8'h0F;
  localparam logic [7:0] RST_LAUNCH  = 8'h00;
  localparam logic [7:0] RST_ADJ     = 8'h00;
  localparam int         LAUNCH_BIT  = 0;

  // sequencer slots
  localparam int         NUM_SLOTS     = 8;
  localparam int         WAIT_FLAG_BIT = 7;

  // mode field encodings
  localparam logic [2:0] MODE_INT_TRIG  = 3'h0;
  localparam logic [2:0] MODE_EXT_EDGE  = 3'h1;
  localparam logic [2:0] MODE_EXT_LEVEL = 3'h2;
  localparam logic [2:0] MODE_DIAG      = 3'h6;
  localparam logic [2:0] MODE_CAL       = 3'h7;

  // library sample full scale marks the overdrive segment
  localparam logic signed [7:0] AMP_MAX = 8'sh7F;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_MS       = 5;
  localparam int WAIT_MS       = 10;
  localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WAIT_TICKS    = WAIT_MS / TICK_MS;

  typedef struct packed {
    logic              last;
    logic [7:0]        dur;
    logic signed [7:0] amp;
  } plt_seg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } plt_reg_req_s;

  typedef logic [NUM_SLOTS-1:0][7:0] plt_slots_t;
endpackage : plt_pkg

// ==== plt_tick_div.sv ====
// divider producing a one-cycle pulse every tick period
`timescale 1ns/1ps
module plt_tick_div import plt_pkg::*; #(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  // clock and reset
  input  logic ref_clk,
  input  logic nrst,
  // control
  input  logic restart,
  output logic tick
);
  localparam int W = $clog2(CYCLES);
  logic [W-1:0] cnt_r;

  always_ff @(posedge ref_clk) begin
    if (!nrst || restart) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r == W'(CYCLES - 1)) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + W'(1);
      tick  <= 1'b0;
    end
  end
endmodule : plt_tick_div

// ==== plt_seg_adjust.sv ====
// trims one library segment duration by its class offset
`timescale 1ns/1ps
module plt_seg_adjust import plt_pkg::*; (
  // segment and offsets
  input  plt_seg_s   seg,
  input  logic [7:0] od_adj,
  input  logic [7:0] sp_adj,
  input  logic [7:0] sn_adj,
  input  logic       closed_loop,
  // adjusted length in ticks
  output logic [8:0] adj_ticks
);
  logic signed [7:0] ofs;
  logic signed [9:0] sum;

  always_comb begin
    if (seg.amp == AMP_MAX) begin
      ofs = closed_loop ? 8'sh00 : $signed(od_adj);
    end else if (seg.amp > 8'sh00) begin
      ofs = $signed(sp_adj);
    end else if (seg.amp < 8'sh00) begin
      ofs = $signed(sn_adj);
    end else begin
      ofs = 8'sh00;
    end
    sum       = $signed({2'b00, seg.dur}) + 10'(ofs);
    adj_ticks = (sum < 10'sh000) ? 9'h000 : sum[8:0];
  end
endmodule : plt_seg_adjust

// ==== plt_lib_model.sv ====
// waveform library model answering segment requests
`timescale 1ns/1ps
module plt_lib_model import plt_pkg::*; (
  // clock
  input  wire logic     ref_clk,
  // request side
  input  wire logic     wave_req_r,
  input  wire logic [6:0] wave_id_r,
  input  wire logic     seg_ready_r,
  // segment offer
  output plt_seg_s      seg_in,
  output logic          seg_valid
);
  logic [6:0] id;
  logic       idx;
  function automatic plt_seg_s seg_of(input logic [6:0] i, input logic x);
    if (i == 7'h01 && !x) return '{1'b0, 8'h03, 8'sh7F};
    if (i == 7'h01) return '{1'b1, 8'h02, 8'sh20};
    return '{1'b1, 8'h01, -8'sh20};
  endfunction : seg_of
  initial begin
    seg_valid = 1'b0;
    seg_in    = '0;
    id        = '0;
    idx       = 1'b0;
  end
  always @(posedge ref_clk) begin
    if (wave_req_r) begin
      id        <= wave_id_r;
      idx       <= 1'b0;
      seg_valid <= 1'b1;
      seg_in    <= seg_of(wave_id_r, 1'b0);
    end else if (seg_valid && seg_ready_r) begin
      idx <= 1'b1;
      if (seg_in.last) begin
        seg_valid <= 1'b0;
        seg_in    <= ~seg_in;
      end else begin
        seg_in <= seg_of(id, 1'b1);
      end
    end
  end
endmodule : plt_lib_model

// ==== test_plt_launch_ctrl.sv ====
// self-checking bench for the launch control and trim registers
`timescale 1ns/1ps
module test_plt_launch_ctrl import plt_pkg::*;;
  localparam int T = 4;
  logic ref_clk = 1'b0, nrst = 1'b0, closed_loop = 1'b0, ext_trig = 1'b0;
  logic routine_done = 1'b0;
  logic [2:0] mode = MODE_INT_TRIG;
  plt_slots_t slots = '0;
  plt_reg_req_s reg_req = '0;
  logic [7:0] reg_rdata_r, drive_amp_r, rv;
  logic [6:0] wave_id_r;
  logic wave_req_r, seg_ready_r, seg_valid, drive_en_r, cal_start_r, diag_start_r, seen;
  plt_seg_s seg_in;
  int err_total = 0, n_checks = 0, cyc = 0, run = 0, i;
  int lens[$];
  logic [6:0] ids[$];
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows[6] = '{'{ADDR_OD_ADJ, 8'hFE, 8'hFE}, '{ADDR_SP_ADJ, 8'h7F, 8'h7F},
    '{ADDR_SN_ADJ, 8'h80, 8'h80}, '{8'h10, 8'h55, 8'h00}, '{8'h00, 8'hAA, 8'h00},
    '{ADDR_OD_ADJ, 8'h01, 8'h01}};

  always #12.5 ref_clk = ~ref_clk;

  plt_launch_ctrl #(.TICK_CYCLES_P(T)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .reg_req(reg_req), .reg_rdata_r(reg_rdata_r), .mode(mode), .slots(slots),
    .closed_loop(closed_loop), .ext_trig(ext_trig), .wave_req_r(wave_req_r),
    .wave_id_r(wave_id_r), .seg_in(seg_in), .seg_valid(seg_valid),
    .seg_ready_r(seg_ready_r), .drive_en_r(drive_en_r), .drive_amp_r(drive_amp_r),
    .cal_start_r(cal_start_r), .diag_start_r(diag_start_r), .routine_done(routine_done));

  plt_lib_model i_lib (.ref_clk(ref_clk), .wave_req_r(wave_req_r), .wave_id_r(wave_id_r),
    .seg_ready_r(seg_ready_r), .seg_in(seg_in), .seg_valid(seg_valid));

  // segment length and request order monitor
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (wave_req_r) ids.push_back(wave_id_r);
    if (drive_en_r) run <= run + 1;
    else if (run > 0) begin
      lens.push_back(run);
      run <= 0;
    end
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk8

  // segment end may land one cycle late
  task automatic chk_len(input int g, input int e);
    n_checks++;
    if (g != e && g != e + 1) begin
      err_total++;
      $display("Error %0t: length %0d want %0d", $time, g, e);
    end
  endtask : chk_len

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    reg_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk);
    reg_req <= '0;
    @(negedge ref_clk);
    d = reg_rdata_r;
  endtask : rd

  task automatic play(input int l0, input int l1);
    lens.delete();
    ids.delete();
    wr(ADDR_LAUNCH, 8'h01);
    for (i = 0; i < 50 && drive_en_r !== 1'b1; i++) @(negedge ref_clk);
    chk8(drive_amp_r, AMP_MAX);
    rd(ADDR_LAUNCH, rv); chk8(rv, 8'h01);
    for (i = 0; i < 60 && rv !== 8'h00; i++) rd(ADDR_LAUNCH, rv);
    chk8(rv, 8'h00);
    chk8(8'(lens.size()), 8'h02);
    chk_len(lens[0], l0);
    chk_len(lens[1], l1);
    chk8({1'b0, ids[0]}, 8'h01);
    chk8({1'b0, ids[1]}, 8'h02);
  endtask : play

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (16) @(negedge ref_clk);
    nrst <= 1'b1;
    for (int a = 12; a < 16; a++) begin
      rd(8'(a), rv); chk8(rv, RST_ADJ);
    end
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a, rv); chk8(rv, rows[k].e);
    end
    wr(ADDR_SP_ADJ, 8'hFF);
    wr(ADDR_SN_ADJ, 8'hFE);
    slots[0] <= 8'h01;
    slots[1] <= 8'h02;
    play(4 * T, T);
    closed_loop <= 1'b1;
    play(3 * T, T);
    closed_loop <= 1'b0;
    wr(ADDR_LAUNCH, 8'h01);
    for (i = 0; i < 50 && drive_en_r !== 1'b1; i++) @(negedge ref_clk);
    wr(ADDR_LAUNCH, 8'h00);
    @(negedge ref_clk);
    chk8({drive_en_r, seg_ready_r, 6'h00}, 8'h00);
    chk8(drive_amp_r, 8'h00);
    rd(ADDR_LAUNCH, rv); chk8(rv, 8'h00);
    for (int m = 0; m < 2; m++) begin
      mode <= m ? MODE_DIAG : MODE_CAL;
      seen = 1'b0;
      wr(ADDR_LAUNCH, 8'h01);
      for (i = 0; i < 8; i++) begin
        @(negedge ref_clk);
        if ((m ? diag_start_r : cal_start_r) === 1'b1) seen = 1'b1;
      end
      chk8({7'h00, seen}, 8'h01);
      chk8({7'h00, drive_en_r}, 8'h00);
      rd(ADDR_LAUNCH, rv); chk8(rv, 8'h01);
      routine_done <= 1'b1;
      @(negedge ref_clk);
      routine_done <= 1'b0;
      rd(ADDR_LAUNCH, rv); chk8(rv, 8'h00);
    end
    slots <= '0;
    mode <= MODE_EXT_LEVEL;
    ext_trig <= 1'b1;
    rd(ADDR_LAUNCH, rv); chk8(rv, 8'h01);
    ext_trig <= 1'b0;
    repeat (2) @(negedge ref_clk);
    rd(ADDR_LAUNCH, rv); chk8(rv, 8'h00);
    // edge mode with a wait slot keeps launch up long enough to read it
    mode <= MODE_EXT_EDGE;
    slots[0] <= 8'h81;
    @(negedge ref_clk);
    ext_trig <= 1'b1;
    rd(ADDR_LAUNCH, rv); chk8(rv, 8'h01);
    ext_trig <= 1'b0;
    chk8({7'h00, drive_en_r}, 8'h00);
    repeat (20) @(negedge ref_clk);
    rd(ADDR_LAUNCH, rv); chk8(rv, 8'h00);
    // reset with the walk idle returns overdrive trim and launch to reset values
    mode <= MODE_INT_TRIG;
    wr(ADDR_OD_ADJ, 8'h33);
    nrst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst <= 1'b1;
    rd(ADDR_OD_ADJ, rv); chk8(rv, RST_ADJ);
    rd(ADDR_LAUNCH, rv); chk8(rv, RST_LAUNCH);
    chk8({drive_en_r, 7'h00}, 8'h00);
    give_verdict();
  end
endmodule : test_plt_launch_ctrl
